/* src/wss_core.sv */
// Purpose: Weld schedule selection and seam sub-mode control.
// Assumes: Closed contact reads 1; weld_cycle pulses once per line cycle.
// Notes:   Registers sit on a plain strobe port, read data one cycle late.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module wss_core
  import wss_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [31:0] rdata,
  // Terminal strip and panel pins
  input  wire wss_pins_s  pins,
  // Sequencer
  input  wire logic       weld_cycle,
  input  wire logic       seq_done,
  output wss_start_s      start,
  output logic            chain_allow,
  output logic            clear_10_20,
  // Weld heat
  output logic            current_on,
  output logic            comp_en,
  output logic      [7:0] pct_out,
  output logic            error_zero,
  output logic      [5:0] disp_sched
);
  typedef struct packed {
    wss_state_e st;
    logic [7:0] seam;
    logic [7:0] ssel;
    logic [5:0] panel;
    logic [7:0] pct;
    logic [7:0] weld1;
    logic [7:0] weld2;
    logic [7:0] pct2;
    logic [7:0] imp;
    logic       chain_pre;
    logic       prev_i1;
    logic       prev_i2;
    logic       prev_i3;
    logic       prev_up;
    logic       prev_dn;
    logic [5:0] seam_sched;
    logic       cur;
    logic [3:0] dly_cnt;
    logic       heat2;
    logic [7:0] ph_cnt;
    logic [7:0] rep;
    wss_start_s start;
    logic       clr;
    logic [31:0] rdata;
  } wss_core_s;

  wss_core_s r;
  wss_core_s next_r;
  wss_pins_s p;

  wss_sync #(.W(PIN_W)) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d       (pins),
    .q       (p)
  );

  // Binary select saturates at the top schedule.
  function automatic logic [5:0] bin_sched(input logic [5:0] b);
    return (b > SCH_TOP) ? SCH_TOP : b;
  endfunction

  function automatic logic [5:0] ext_sched(input logic s2, input logic s3);
    case ({s3, s2})
      2'b01:   return SCH_10;
      2'b10:   return SCH_20;
      2'b11:   return SCH_30;
      default: return SCH_00;
    endcase
  endfunction

  logic r1, r2, r3, up_e, dn_e, dly_mode, nb_mode;
  logic [3:0] dly_x;

  always_comb begin
    next_r       = r;
    r1           = p.init1 & ~r.prev_i1;
    r2           = p.init2 & ~r.prev_i2;
    r3           = p.init3 & ~r.prev_i3;
    up_e         = p.btn_up & ~r.prev_up;
    dn_e         = p.btn_dn & ~r.prev_dn;
    dly_mode     = (r.seam[3:0] == SEAM_DLY_LO);
    dly_x        = r.seam[7:4];
    nb_mode      = (r.seam == SEAM_NONBEAT);
    next_r.prev_i1 = p.init1;
    next_r.prev_i2 = p.init2;
    next_r.prev_i3 = p.init3;
    next_r.prev_up = p.btn_up;
    next_r.prev_dn = p.btn_dn;
    next_r.start   = '0;
    next_r.clr     = 1'b0;
    next_r.rdata   = '0;

    // Register writes.
    if (wr) begin
      case (addr)
        ADR_SEAM: next_r.seam = wdata[7:0];
        ADR_SSEL: begin
          if (wdata[7:0] == SSEL_INT || wdata[7:0] == SSEL_EXT ||
              (wdata[7:0] == SSEL_BIN && p.opt_present)) begin
            next_r.ssel = wdata[7:0];
            next_r.clr  = (wdata[7:0] == SSEL_INT) &&
                          (r.ssel != SSEL_INT);
          end
        end
        ADR_PANEL: begin
          if (r.ssel == SSEL_INT) next_r.panel = wdata[5:0];
        end
        ADR_PCT:  next_r.pct = wdata[7:0];
        ADR_WELD: begin
          next_r.weld1 = wdata[7:0];
          next_r.weld2 = wdata[15:8];
          next_r.pct2  = wdata[23:16];
          next_r.imp   = wdata[31:24];
        end
        ADR_CTRL: next_r.chain_pre = wdata[CTRL_CHAIN_POS];
        default: ;
      endcase
    end

    // Register reads, answered in the next cycle.
    if (rd) begin
      case (addr)
        ADR_SEAM:  next_r.rdata = {24'h0, r.seam};
        ADR_SSEL:  next_r.rdata = {24'h0, r.ssel};
        ADR_PANEL: next_r.rdata = {26'h0, r.panel};
        ADR_PCT:   next_r.rdata = {24'h0, r.pct};
        ADR_WELD:  next_r.rdata = {r.imp, r.pct2, r.weld2, r.weld1};
        ADR_CTRL:  next_r.rdata = {31'h0, r.chain_pre};
        ADR_STAT:  next_r.rdata = {16'h0, 2'(r.st), r.heat2, comp_en,
                                   r.cur, p.opt_present, ~p.temp_ok,
                                   1'b0, 2'h0, disp_sched};
        default:   next_r.rdata = '0;
      endcase
    end

    case (r.st)
      ST_IDLE: begin
        next_r.cur = 1'b0;
        if (p.temp_ok) begin
          if (r.seam == SEAM_SPOT) begin
            case (r.ssel)
              SSEL_EXT: begin
                if (r1) begin
                  next_r.start = '{1'b1, ext_sched(p.init2, p.init3), 1'b1};
                  next_r.st    = ST_SPOT;
                end
              end
              SSEL_BIN: begin
                if (r1) begin
                  next_r.start = '{1'b1, bin_sched(p.bsel), 1'b1};
                  next_r.st    = ST_SPOT;
                end else if (r3) begin
                  next_r.start = '{1'b1, SCH_20, 1'b1};
                  next_r.st    = ST_SPOT;
                end else if (r2) begin
                  next_r.start = '{1'b1, SCH_10, 1'b1};
                  next_r.st    = ST_SPOT;
                end
              end
              default: begin
                if (r3) begin
                  next_r.start = '{1'b1, SCH_20, 1'b1};
                  next_r.st    = ST_SPOT;
                end else if (r2) begin
                  next_r.start = '{1'b1, SCH_10, 1'b1};
                  next_r.st    = ST_SPOT;
                end else if (r1) begin
                  next_r.start = '{1'b1, r.panel, 1'b1};
                  next_r.st    = ST_SPOT;
                end
              end
            endcase
          end else if (r.seam == SEAM_COMBO && r2) begin
            next_r.start = '{1'b1, SCH_10, 1'b1};
            next_r.st    = ST_SPOT;
          end else if (r1) begin
            next_r.seam_sched = disp_sched;
            if (r.seam == SEAM_COMBO && r.chain_pre) begin
              next_r.start = '{1'b1, disp_sched, 1'b1};
              next_r.st    = ST_PRE_SPOT;
            end else begin
              next_r.start = '{1'b1, disp_sched, 1'b0};
              next_r.st    = ST_SEAM;
            end
          end
        end
      end
      ST_PRE_SPOT: begin
        if (seq_done) begin
          next_r.start = '{1'b1, r.seam_sched, 1'b0};
          next_r.st    = ST_SEAM;
        end
      end
      ST_SEAM: begin
        if (r.seam == SEAM_COMBO && r2) begin
          next_r.cur   = 1'b0;
          next_r.start = '{1'b1, SCH_10, 1'b1};
          next_r.st    = ST_SPOT;
        end else if (weld_cycle) begin
          // Current changes on a line cycle boundary, except that a combo jump to spot drops it at once.
          next_r.cur = p.init1;
          if (!p.init1) next_r.st = ST_IDLE;
          if (r.cur && dly_mode && r.dly_cnt != dly_x)
            next_r.dly_cnt = r.dly_cnt + 4'h1;
          if (r.cur && nb_mode) begin
            if (r.ph_cnt + 8'h1 >= (r.heat2 ? r.weld2 : r.weld1)) begin
              next_r.ph_cnt = '0;
              next_r.heat2  = ~r.heat2;
              if (r.heat2) begin
                next_r.rep = r.rep + 8'h1;
                if (r.rep + 8'h1 >= r.imp) begin
                  next_r.cur = 1'b0;
                  next_r.st  = ST_IDLE;
                end
              end
            end else begin
              next_r.ph_cnt = r.ph_cnt + 8'h1;
            end
          end
        end
        if (r.seam == SEAM_ADJUST && r.cur) begin
          if (up_e && r.pct < PCT_MAX) next_r.pct = r.pct + 8'h1;
          else if (dn_e && r.pct != 8'h0) next_r.pct = r.pct - 8'h1;
        end
      end
      ST_SPOT: begin
        next_r.cur = 1'b0;
        if (seq_done) next_r.st = ST_IDLE;
      end
      default: next_r.st = ST_IDLE;
    endcase

    if (next_r.st != ST_SEAM || !next_r.cur) begin
      next_r.dly_cnt = '0;
      next_r.heat2   = 1'b0;
      next_r.ph_cnt  = '0;
      next_r.rep     = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r       <= '0;
      r.st    <= ST_IDLE;
      r.seam  <= SEAM_SPOT;
      r.ssel  <= SSEL_INT;
      r.pct   <= PCT_RST;
      r.weld1 <= WELD_RST;
      r.weld2 <= WELD_RST;
      r.pct2  <= PCT_RST;
      r.imp   <= IMP_RST;
    end else begin
      r <= next_r;
    end
  end

  // Seam modes offer no chaining except combo mode whenever it is outside the seam state.
  assign chain_allow = (r.seam == SEAM_SPOT) ||
                       (r.seam == SEAM_COMBO && r.st != ST_SEAM);
  assign start       = r.start;
  assign clear_10_20 = r.clr;
  assign current_on  = r.cur;
  assign comp_en     = r.cur && (!(r.seam[3:0] == SEAM_DLY_LO) ||
                       r.dly_cnt == r.seam[7:4]);
  assign pct_out     = r.heat2 ? r.pct2 : r.pct;
  assign error_zero  = ~p.temp_ok;
  assign disp_sched  = (r.ssel == SSEL_BIN) ? bin_sched(p.bsel) : r.panel;
  assign rdata       = r.rdata;

  // Assertions.
  sequence s_ext_go;
    r.st == ST_IDLE && r.seam == SEAM_SPOT && r.ssel == SSEL_EXT &&
    p.temp_ok && p.init1 && !r.prev_i1;
  endsequence

  sequence s_combo_jump;
    r.st == ST_SEAM && r.seam == SEAM_COMBO && p.init2 && !r.prev_i2;
  endsequence

  AST_ERR_ZERO: assert property (@(posedge clk_sys) disable iff (reset)
    error_zero == !p.temp_ok)
    else $error("error zero does not follow limit switch");

  AST_EXT_MAP: assert property (@(posedge clk_sys) disable iff (reset)
    s_ext_go |=> start.valid && start.sched == ext_sched($past(p.init2),
                                                         $past(p.init3)))
    else $error("external select mapped wrong schedule");

  AST_COMBO_SPOT: assert property (@(posedge clk_sys) disable iff (reset)
    s_combo_jump |=> start.valid && start.spot && start.sched == SCH_10 &&
                     !current_on)
    else $error("combo mode failed to jump to spot on 10");

  AST_BIN_CAP: assert property (@(posedge clk_sys) disable iff (reset)
    (r.ssel == SSEL_BIN && p.bsel > SCH_TOP) |-> disp_sched == SCH_TOP)
    else $error("binary value above top not shown as 49");

  AST_CLEAR: assert property (@(posedge clk_sys) disable iff (reset)
    (wr && addr == ADR_SSEL && wdata[7:0] == SSEL_INT &&
     r.ssel != SSEL_INT) |=> clear_10_20 ##1 !clear_10_20)
    else $error("schedules 10 and 20 not cleared once");

  AST_BIN_OPT: assert property (@(posedge clk_sys) disable iff (reset)
    (wr && addr == ADR_SSEL && wdata[7:0] == SSEL_BIN && !p.opt_present)
    |=> r.ssel == $past(r.ssel))
    else $error("binary select taken without option");

  AST_PANEL_LOCK: assert property (@(posedge clk_sys) disable iff (reset)
    (wr && addr == ADR_PANEL && r.ssel != SSEL_INT) |=> $stable(r.panel))
    else $error("panel schedule changed in external mode");

  AST_CUR_SYNC: assert property (@(posedge clk_sys) disable iff (reset)
    (!weld_cycle && r.st == ST_SEAM && !(r.seam == SEAM_COMBO &&
     p.init2 && !r.prev_i2)) |=> $stable(current_on))
    else $error("seam current changed off a cycle boundary");

  AST_DLY_COMP: assert property (@(posedge clk_sys) disable iff (reset)
    (current_on && r.seam[3:0] == SEAM_DLY_LO &&
     r.dly_cnt < r.seam[7:4]) |-> !comp_en)
    else $error("compensation began inside the delay");
endmodule // wss_core
`default_nettype wire

/* include/wss_pkg.sv */
// Purpose: Shared constants and carriers of the weld schedule select block.
// Assumes: Register offsets are byte addresses of 32-bit words.
// Notes:   Schedule and percent values are plain binary; seam delay codes use one nibble per digit.
package wss_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADR_SEAM  = 8'h00;
  localparam logic [7:0] ADR_SSEL  = 8'h04;
  localparam logic [7:0] ADR_PANEL = 8'h08;
  localparam logic [7:0] ADR_PCT   = 8'h0c;
  localparam logic [7:0] ADR_WELD  = 8'h10;
  localparam logic [7:0] ADR_CTRL  = 8'h14;
  localparam logic [7:0] ADR_STAT  = 8'h18;
  // Seam parameter values.
  localparam logic [7:0] SEAM_SPOT    = 8'h00;
  localparam logic [7:0] SEAM_ADJUST  = 8'h02;
  localparam logic [7:0] SEAM_COMBO   = 8'h03;
  localparam logic [7:0] SEAM_NONBEAT = 8'h05;
  localparam logic [3:0] SEAM_DLY_LO  = 4'h4;
  // Schedule select parameter values.
  localparam logic [7:0] SSEL_INT = 8'h00;
  localparam logic [7:0] SSEL_EXT = 8'h01;
  localparam logic [7:0] SSEL_BIN = 8'h03;
  // Fixed schedules and percent limit.
  localparam logic [5:0] SCH_00  = 6'h00;
  localparam logic [5:0] SCH_10  = 6'h0a;
  localparam logic [5:0] SCH_20  = 6'h14;
  localparam logic [5:0] SCH_30  = 6'h1e;
  localparam logic [5:0] SCH_TOP = 6'h31;
  localparam logic [7:0] PCT_MAX = 8'h63;
  // Reset values.
  localparam logic [7:0] PCT_RST   = 8'h32;
  localparam logic [7:0] WELD_RST  = 8'h01;
  localparam logic [7:0] IMP_RST   = 8'h01;
  // Control register field positions and pin bus width.
  localparam int CTRL_CHAIN_POS = 0;
  localparam int PIN_W          = 13;

  typedef enum {ST_IDLE, ST_PRE_SPOT, ST_SEAM, ST_SPOT} wss_state_e;

  typedef struct packed {
    logic       init1;
    logic       init2;
    logic       init3;
    logic [5:0] bsel;
    logic       opt_present;
    logic       temp_ok;
    logic       btn_up;
    logic       btn_dn;
  } wss_pins_s;

  typedef struct packed {
    logic       valid;
    logic [5:0] sched;
    logic       spot;
  } wss_start_s;
endpackage

/* src/wss_sync.sv */
// Purpose: Three-stage synchroniser for panel and terminal strip inputs.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes:   A bit changes only once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module wss_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } wss_sync_s;

  wss_sync_s r;
  wss_sync_s next_r;

  initial begin
    if (W < 1) $error("wss_sync width must be positive");
  end

  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) next_r.q[i] = r.s3[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) r <= '0;
    else       r <= next_r;
  end

  assign q = r.q;
endmodule // wss_sync
`default_nettype wire

/* tb/wss_switch_model.sv */
// Purpose: Switch contacts, line timebase and spot sequencer beside the core.
// Assumes: Closed contact drives 1; requests change after a rising edge.
// Notes:   The primary contact only closes once the select lines settled.
`timescale 1ns/1ns
`default_nettype none
module wss_switch_model
  import wss_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Requests from the bench and start requests from the core
  input  wire wss_pins_s  req,
  input  wire wss_start_s start,
  // Contacts and sequencer
  output var wss_pins_s   pins,
  output logic            weld_cycle,
  output logic            seq_done
);
  logic [3:0] tick;
  logic [3:0] settle;
  logic [3:0] busy;
  logic [7:0] sel_q;
  logic [7:0] sel_d;
  wss_pins_s  nxt;

  assign sel_d = {req.init2, req.init3, req.bsel};

  // The primary contact waits until the select lines have settled.
  always_comb begin
    nxt       = req;
    nxt.init1 = req.init1 & (pins.init1 | (settle > 4'h7));
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tick       <= 4'h0;
      settle     <= 4'h0;
      busy       <= 4'h0;
      sel_q      <= 8'h00;
      pins       <= '0;
      weld_cycle <= 1'b0;
      seq_done   <= 1'b0;
    end else begin
      tick       <= tick + 4'h1;
      weld_cycle <= (tick == 4'hf);
      sel_q      <= sel_d;
      // Select lines must stand still before the primary contact closes.
      if (sel_d != sel_q) begin
        settle <= 4'h0;
      end else if (settle != 4'hf) begin
        settle <= settle + 4'h1;
      end
      pins       <= nxt;
      // A spot sequence ends a fixed time after it was started.
      if (start.valid && start.spot) begin
        busy <= 4'ha;
      end else if (busy != 4'h0) begin
        busy <= busy - 4'h1;
      end
      seq_done <= (busy == 4'h1);
    end
  end
endmodule // wss_switch_model
`default_nettype wire

/* tb/tb_wss_core.sv */
// Purpose: Self-checking bench of the schedule select and seam core.
// Assumes: The switch model supplies contacts, timebase and sequence end.
// Notes:   Expected values come from the bench functions and constants.
`timescale 1ns/1ns
`default_nettype none
module tb_wss_core
  import wss_pkg::*;
;
  logic        clk_sys;
  logic        reset;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  wss_pins_s   req;
  wss_pins_s   base;
  wss_pins_s   pins;
  logic        weld_cycle;
  logic        seq_done;
  wss_start_s  start;
  logic        chain_allow;
  logic        clear_10_20;
  logic        current_on;
  logic        comp_en;
  logic [7:0]  pct_out;
  logic        error_zero;
  logic [5:0]  disp_sched;
  logic [5:0]  p;
  logic [5:0]  b;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;

  wss_core i_wss_core (.clk_sys(clk_sys), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pins(pins),
    .weld_cycle(weld_cycle), .seq_done(seq_done), .start(start),
    .chain_allow(chain_allow), .clear_10_20(clear_10_20),
    .current_on(current_on), .comp_en(comp_en), .pct_out(pct_out),
    .error_zero(error_zero), .disp_sched(disp_sched));

  wss_switch_model i_wss_switch_model (.clk_sys(clk_sys), .reset(reset),
    .req(req), .start(start), .pins(pins), .weld_cycle(weld_cycle),
    .seq_done(seq_done));

  function automatic logic [5:0] f_ext(input logic s2, input logic s3);
    return s3 ? (s2 ? SCH_30 : SCH_20) : (s2 ? SCH_10 : SCH_00);
  endfunction

  function automatic logic [5:0] f_bin(input logic [5:0] v);
    return (v >= 6'h32) ? SCH_TOP : v;
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic put(input wss_pins_s v);
    @(posedge clk_sys);
    req <= v;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask

  // Looks for a start pulse in a bounded window, or checks that none comes.
  task automatic exp_start(input logic v, input logic [5:0] s,
                           input logic sp);
    int  i;
    logic hit;
    hit = 1'b0;
    for (i = 0; i < 40 && !hit; i++) begin
      @(posedge clk_sys);
      #1;
      hit = (start.valid === 1'b1);
    end
    chk("start.valid", v, hit);
    if (hit) begin
      chk("start.sched", s, start.sched);
      chk("start.spot", sp, start.spot);
    end
  endtask

  task automatic fire(input logic [2:0] ini, input logic [5:0] s);
    wss_pins_s v;
    v = base;
    {v.init1, v.init2, v.init3} = ini;
    put(v);
    exp_start(1'b1, s, 1'b1);
    put(base);
    idle(40);
  endtask

  // Steps to the cycle just after the core has seen a line-cycle pulse.
  task automatic wc();
    do begin
      @(posedge clk_sys);
      #1;
    end while (weld_cycle !== 1'b1);
    idle(1);
  endtask

  task automatic seam_go(input logic [7:0] mode, input logic sp);
    wss_pins_s v;
    v = base;
    v.init1 = 1'b1;
    wr_reg(ADR_SEAM, {24'h0, mode});
    put(v);
    exp_start(1'b1, p, sp);
  endtask

  task automatic seam_end();
    put(base);
    wc();
    wc();
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      results();
    end
  end

  initial begin
    wss_pins_s v;
    int k;
    base = '0;
    base.temp_ok = 1'b1;
    req = base;
    reset = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    void'($urandom(43));
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    idle(6);
    rd_chk(ADR_SEAM, {24'h0, SEAM_SPOT});
    rd_chk(ADR_SSEL, {24'h0, SSEL_INT});
    rd_chk(ADR_PCT, {24'h0, PCT_RST});
    rd_chk(ADR_WELD, {IMP_RST, PCT_RST, WELD_RST, WELD_RST});
    rd_chk(8'h1c, 32'h0);
    chk("chain_allow", 1'b1, chain_allow);
    p = 6'($urandom_range(49, 1));
    wr_reg(ADR_PANEL, {26'h0, p});
    fire(3'b100, p);
    fire(3'b010, SCH_10);
    fire(3'b001, SCH_20);
    v = base;
    v.temp_ok = 1'b0;
    put(v);
    idle(8);
    chk("error_zero", 1'b1, error_zero);
    v.init1 = 1'b1;
    put(v);
    exp_start(1'b0, SCH_00, 1'b0);
    put(base);
    idle(40);
    chk("error_zero", 1'b0, error_zero);
    wr_reg(ADR_SSEL, 32'h2);
    rd_chk(ADR_SSEL, {24'h0, SSEL_INT});
    wr_reg(ADR_SSEL, {24'h0, SSEL_EXT});
    rd_chk(ADR_SSEL, {24'h0, SSEL_EXT});
    wr_reg(ADR_PANEL, 32'h5);
    for (k = 0; k < 4; k++) begin
      v = base;
      v.init2 = k[0];
      v.init3 = k[1];
      put(v);
      exp_start(1'b0, SCH_00, 1'b0);
      v.init1 = 1'b1;
      put(v);
      exp_start(1'b1, f_ext(k[0], k[1]), 1'b1);
      put(base);
      idle(40);
    end
    wr_reg(ADR_SSEL, {24'h0, SSEL_BIN});
    rd_chk(ADR_SSEL, {24'h0, SSEL_EXT});
    wr_reg(ADR_SSEL, {24'h0, SSEL_INT});
    chk("clear_10_20", 1'b1, clear_10_20);
    idle(1);
    chk("clear_10_20", 1'b0, clear_10_20);
    rd_chk(ADR_PANEL, {26'h0, p});
    base.opt_present = 1'b1;
    put(base);
    idle(8);
    wr_reg(ADR_SSEL, {24'h0, SSEL_BIN});
    rd_chk(ADR_SSEL, {24'h0, SSEL_BIN});
    v = base;
    for (k = 0; k < 6; k++) begin
      b = (k == 0) ? 6'h31 : (k == 1) ? 6'h32 : (k == 2) ? 6'h3f :
          6'($urandom_range(63, 0));
      v.bsel = b;
      put(v);
      idle(12);
      chk("disp_sched", f_bin(b), disp_sched);
    end
    v.init1 = 1'b1;
    put(v);
    exp_start(1'b1, f_bin(b), 1'b1);
    put(base);
    idle(40);
    wr_reg(ADR_SSEL, {24'h0, SSEL_INT});
    seam_go(8'h01, 1'b0);
    chk("chain_allow", 1'b0, chain_allow);
    wc();
    chk("current_on", 1'b1, current_on);
    seam_end();
    chk("current_on", 1'b0, current_on);
    seam_go(8'h24, 1'b0);
    wc();
    chk("comp_en", 1'b0, comp_en);
    wc();
    chk("comp_en", 1'b0, comp_en);
    wc();
    chk("comp_en", 1'b1, comp_en);
    seam_end();
    // Buttons only act once seam current is on.
    seam_go(SEAM_ADJUST, 1'b0);
    wc();
    v = base;
    v.init1 = 1'b1;
    for (k = 0; k < 3; k++) begin
      v.btn_up = (k == 0);
      v.btn_dn = (k != 0);
      put(v);
      idle(8);
      v.btn_up = 1'b0;
      v.btn_dn = 1'b0;
      put(v);
      idle(8);
      chk("pct_out", 8'(PCT_RST + 8'h1 - 8'(k)), pct_out);
    end
    seam_end();
    // Three cycles of heat one, two of heat two, two pairs in all.
    wr_reg(ADR_PCT, 32'h40);
    wr_reg(ADR_WELD, 32'h02140203);
    rd_chk(ADR_WELD, 32'h02140203);
    seam_go(SEAM_NONBEAT, 1'b0);
    wc();
    chk("pct_out", 8'h40, pct_out);
    repeat (3) wc();
    chk("pct_out", 8'h14, pct_out);
    repeat (2) wc();
    chk("pct_out", 8'h40, pct_out);
    repeat (5) wc();
    chk("current_on", 1'b0, current_on);
    seam_end();
    seam_go(SEAM_COMBO, 1'b0);
    v.init2 = 1'b1;
    put(v);
    exp_start(1'b1, SCH_10, 1'b1);
    seam_end();
    idle(40);
    wr_reg(ADR_CTRL, 32'h1);
    seam_go(SEAM_COMBO, 1'b1);
    exp_start(1'b1, p, 1'b0);
    seam_end();
    results();
  end
endmodule // tb_wss_core
`default_nettype wire
